// ### verilog/dram_ecc_glue.sv
/*
   Top of the memory glue timing block: taps, midpoint, error latch, refresh mode.
   Assumes all inputs are synchronous to sys_clk and enables are one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module dram_ecc_glue (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic fast_clock,
   input wire logic delay_chain_clock,
   input wire logic row_strobe_in,
   input wire logic refresh_request,
   input wire logic read_cycle,
   input wire logic any_error,
   output logic tap_two,
   output logic tap_four,
   output logic tap_six,
   output logic tap_eight,
   output logic cycle_midpoint,
   output logic error_latched,
   output logic [2:0] ctrl_mode
);
   import glue_pkg::*;

   // Bundle of the four tap outputs coming back from the chain.
   tap_if taps ();
   logic start_evt; // Cycle start: strobe or refresh request.
   logic [2:0] mode_nxt; // Next controller mode code.
   cycle_kind_t kind_r; // Kind of the cycle in progress.

   // A memory access and a refresh both start the same timing chain, so the
   // chain sees one merged event. Which kind of cycle it was is kept apart in
   // kind_r, so that the error latch can tell a read from the others.
   // Both inputs are taken as already synchronous to sys_clk.
   assign start_evt = row_strobe_in | refresh_request;

   // Shared delay chain. Its four taps give the timing points of a cycle.
   // They are registered again below so that every pin of this block comes
   // straight from a flip-flop, which costs one edge of latency on each tap.
   tap_chain u_chain (
      .sys_clk(sys_clk),
      .rst(rst),
      .fast_clock(fast_clock),
      .delay_chain_clock(delay_chain_clock),
      .start_evt(start_evt),
      .taps(taps)
   );

   // Register the taps so outputs come from flip-flops.
   // The extra edge is the same for all four taps, so their spacing is kept.
   // Reset clears them together with the chain itself.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tap_two <= TAP_RESET;
         tap_four <= TAP_RESET;
         tap_six <= TAP_RESET;
         tap_eight <= TAP_RESET;
      end else begin
         tap_two <= taps.tap_two;
         tap_four <= taps.tap_four;
         tap_six <= taps.tap_six;
         tap_eight <= taps.tap_eight;
      end
   end

   // Track the kind of cycle; refresh outranks a read.
   // The kind is sampled on every edge while the event stands, so a late
   // read_cycle level is still seen before the midpoint arrives.
   // It falls back to idle as soon as the merged event drops.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         kind_r <= CYC_IDLE;
      end else if (!start_evt) begin
         // No strobe and no refresh: the bus is between cycles.
         kind_r <= CYC_IDLE;
      end else if (refresh_request) begin
         // A refresh never counts as a read, even with read_cycle up.
         kind_r <= CYC_REFRESH;
      end else if (read_cycle) begin
         // Plain read access: errors found now are of interest.
         kind_r <= CYC_READ;
      end else begin
         // Everything else that starts a cycle is a write.
         kind_r <= CYC_WRITE;
      end
   end

   // Midpoint: cycle has reached tap four but not tap eight.
   // Tap four is half of the eight-period span, so the flag rises halfway
   // through the cycle and falls when the last tap arrives. It is taken
   // from the chain before the output registers, so it lines up with them.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cycle_midpoint <= 1'b0;
      end else begin
         cycle_midpoint <= taps.tap_four & ~taps.tap_eight;
      end
   end

   // Error latch: sampled at midpoint of read cycles, held until cycle ends.
   // The midpoint qualifier keeps early, unsettled any_error levels out.
   // If a new error and the end of the cycle fall in one edge, the set wins,
   // so an error seen on the last edge of a read is never lost.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         error_latched <= TAP_RESET;
      end else if (cycle_midpoint && kind_r == CYC_READ && any_error) begin
         // Error reported while a read is halfway through.
         error_latched <= 1'b1;
      end else if (!start_evt) begin
         // Cycle over: get ready for the next one.
         error_latched <= 1'b0;
      end
   end

   // Controller mode follows the refresh request.
   // Any other time the controller is left in its normal access mode.
   always_comb begin
      mode_nxt = refresh_request ? MODE_REFRESH : MODE_NORMAL;
   end

   // Mode register, so the mode pins come straight from flip-flops.
   // The mode therefore lags the refresh request by one edge.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_mode <= MODE_NORMAL;
      end else begin
         ctrl_mode <= mode_nxt;
      end
   end

   // Checks on the glue outputs. Each one watches the registered outputs or
   // the state that drives them, so a broken equation shows at the edge
   // where its output first goes wrong.

   // An error may only be caught at the midpoint of a read with any_error up.
   chk_err_read_only: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(error_latched) |-> $past(kind_r == CYC_READ && any_error && cycle_midpoint))
      else $error("error latched outside read midpoint");

   // The midpoint flag is only raised inside the tap four to tap eight span.
   chk_mid_window: assert property (@(posedge sys_clk) disable iff (rst)
      cycle_midpoint |-> $past(taps.tap_four) && !$past(taps.tap_eight))
      else $error("midpoint outside window");

   // The midpoint agrees with the tap outputs registered beside it.
   chk_mid_taps: assert property (@(posedge sys_clk) disable iff (rst)
      cycle_midpoint |-> tap_four && !tap_eight)
      else $error("midpoint disagrees with taps");

   // A refresh request puts the controller into refresh mode on the next edge.
   chk_refresh_mode: assert property (@(posedge sys_clk) disable iff (rst)
      refresh_request |=> ctrl_mode == MODE_REFRESH)
      else $error("refresh did not set mode one");

   // Reset clears the taps and the error latch.
   chk_reset_clear: assert property (@(posedge sys_clk)
      rst |=> !tap_two && !tap_four && !tap_six && !tap_eight && !error_latched)
      else $error("reset did not clear outputs");

   // Reset also returns the controller mode and the midpoint flag to rest.
   chk_reset_rest: assert property (@(posedge sys_clk)
      rst |=> ctrl_mode == MODE_NORMAL && !cycle_midpoint)
      else $error("reset left mode or midpoint set");

   // Output copies of the taps lag the chain by exactly one edge.
   chk_tap_two_copy: assert property (@(posedge sys_clk) disable iff (rst)
      1 |=> tap_two == $past(taps.tap_two))
      else $error("tap two output mismatch");

   // The last tap keeps the same one-edge lag as the first.
   chk_tap_eight_copy: assert property (@(posedge sys_clk) disable iff (rst)
      1 |=> tap_eight == $past(taps.tap_eight))
      else $error("tap eight output mismatch");

   // A write cycle never raises the error latch.
   chk_no_err_write: assert property (@(posedge sys_clk) disable iff (rst)
      (kind_r == CYC_WRITE && !error_latched) |=> !error_latched)
      else $error("error latched in write");

   // A refresh cycle never raises the error latch either.
   chk_no_err_refresh: assert property (@(posedge sys_clk) disable iff (rst)
      (kind_r == CYC_REFRESH && !error_latched) |=> !error_latched)
      else $error("error latched in refresh");

   // A refresh that overlaps a read level is still treated as a refresh.
   chk_refresh_first: assert property (@(posedge sys_clk) disable iff (rst)
      (refresh_request && read_cycle) |=> kind_r == CYC_REFRESH)
      else $error("read outranked refresh");

   // A caught error stands for as long as the cycle does.
   chk_err_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (error_latched && start_evt) |=> error_latched)
      else $error("error latch dropped inside cycle");

   // Once the cycle has ended and nothing new is caught, the latch lets go.
   chk_err_release: assert property (@(posedge sys_clk) disable iff (rst)
      (error_latched && !start_evt && !(cycle_midpoint && kind_r == CYC_READ && any_error))
      |=> !error_latched)
      else $error("error latch stuck after cycle");

   // Without a refresh request the controller goes back to normal mode.
   chk_mode_normal: assert property (@(posedge sys_clk) disable iff (rst)
      !refresh_request |=> ctrl_mode == MODE_NORMAL)
      else $error("mode stuck in refresh");

   // Main scenarios: a caught read error, a midpoint, a refresh, an ignored error.
   cov_read_error: cover property (@(posedge sys_clk) disable iff (rst) $rose(error_latched));
   cov_midpoint: cover property (@(posedge sys_clk) disable iff (rst) $rose(cycle_midpoint));
   cov_refresh: cover property (@(posedge sys_clk) disable iff (rst) ctrl_mode == MODE_REFRESH);
   cov_err_ignored: cover property (@(posedge sys_clk) disable iff (rst)
      kind_r == CYC_REFRESH && cycle_midpoint && any_error);
endmodule : dram_ecc_glue
`default_nettype wire

// ### verilog/glue_pkg.sv
/*
   Package for the memory glue timing block: state names, tap counts and widths.
   Assumes a single 250 MHz system clock and a synchronous active-high reset.

   // Summary of operation
   // - First tap repeats strobe two fast periods later.
   // - Each later tap adds two chain periods.
   // - Error latches only on read-cycle any-error.
   // - Midpoint flag marks half of access cycle.
*/
package glue_pkg;
   // Periods of delay per tap, in the tap's own clock.
   localparam int TAP_PERIODS = 2;
   // Reset value of every tap and latch.
   localparam logic TAP_RESET = 1'b0;
   // Controller mode codes; refresh is mode one.
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_REFRESH = 3'h1;
   // Cycle kinds seen by the glue logic.
   typedef enum {CYC_IDLE, CYC_READ, CYC_WRITE, CYC_REFRESH} cycle_kind_t;
endpackage : glue_pkg

// ### verilog/tap_if.sv
/*
   Interface carrying the tap chain outputs between the top and the chain.
   Assumes both ends run on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
interface tap_if;
   logic tap_two;   // Event delayed two fast-clock periods.
   logic tap_four;  // Delayed two fast-clock plus two chain periods.
   logic tap_six;   // Delayed two fast-clock plus four chain periods.
   logic tap_eight; // Delayed two fast-clock plus six chain periods.
   modport chain (output tap_two, tap_four, tap_six, tap_eight);
   modport user (input tap_two, tap_four, tap_six, tap_eight);
endinterface : tap_if
`default_nettype wire

// ### verilog/tap_chain.sv
/*
   Tapped shift chain producing delayed copies of the cycle-start event.
   Assumes fast_clock and delay_chain_clock are one-cycle enables on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module tap_chain (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic fast_clock,
   input wire logic delay_chain_clock,
   input wire logic start_evt,
   tap_if.chain taps
);
   import glue_pkg::*;

   // Two-stage pipes; the last stage of each is the tap.
   logic [1:0] pipe2_r;
   logic [1:0] pipe4_r;
   logic [1:0] pipe6_r;
   logic [1:0] pipe8_r;

   // First tap advances on the fast clock enable.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pipe2_r <= {2{TAP_RESET}};
      end else if (fast_clock) begin
         pipe2_r <= {pipe2_r[0], start_evt};
      end
   end

   // Later taps advance on the chain clock enable, two stages each.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pipe4_r <= {2{TAP_RESET}};
         pipe6_r <= {2{TAP_RESET}};
         pipe8_r <= {2{TAP_RESET}};
      end else if (delay_chain_clock) begin
         pipe4_r <= {pipe4_r[0], pipe2_r[1]};
         pipe6_r <= {pipe6_r[0], pipe4_r[1]};
         pipe8_r <= {pipe8_r[0], pipe6_r[1]};
      end
   end

   assign taps.tap_two = pipe2_r[1];
   assign taps.tap_four = pipe4_r[1];
   assign taps.tap_six = pipe6_r[1];
   assign taps.tap_eight = pipe8_r[1];

   // Checks on the chain timing.
   chk_tap_two_delay: assert property (@(posedge sys_clk) disable iff (rst)
      fast_clock |=> (pipe2_r[0] == $past(start_evt)) && (pipe2_r[1] == $past(pipe2_r[0])))
      else $error("tap two timing broken");
   chk_tap_four_follow: assert property (@(posedge sys_clk) disable iff (rst)
      delay_chain_clock |=> (pipe4_r[0] == $past(pipe2_r[1])))
      else $error("tap four does not follow tap two");
   chk_tap_step_six: assert property (@(posedge sys_clk) disable iff (rst)
      delay_chain_clock |=> (pipe6_r[1] == $past(pipe6_r[0])))
      else $error("tap six stage slip");
   chk_tap_step_eight: assert property (@(posedge sys_clk) disable iff (rst)
      !delay_chain_clock |=> $stable(pipe8_r))
      else $error("tap eight moved without chain clock");
   cov_tap_eight_high: cover property (@(posedge sys_clk) disable iff (rst) taps.tap_eight);
endmodule : tap_chain
`default_nettype wire

// ### sim/ctrl_model.sv
/*
   Far-side model: produces the fast and delay-chain clock enables.
   Assumes sys_clk and a synchronous active-high reset from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module ctrl_model (
   input wire logic sys_clk,
   input wire logic rst,
   output logic fast_clock,
   output logic delay_chain_clock
);
   // Both enables pulse on every cycle outside reset, the fastest legal rate.
   always_ff @(posedge sys_clk) begin
      fast_clock <= #1 !rst;
      delay_chain_clock <= #1 !rst;
   end
endmodule : ctrl_model
`default_nettype wire

// ### sim/testbench.sv
/*
   Self-checking bench for the memory glue timing block.
   Assumes the enables come from the far-side model on every cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import glue_pkg::*;
   logic sys_clk = 1'b0; // System clock, 4 ns period.
   logic rst = 1'b1; // Reset, held for three cycles.
   logic row_strobe_in = 1'b0, refresh_request = 1'b0, read_cycle = 1'b0, any_error = 1'b0;
   wire logic fast_clock, delay_chain_clock;
   logic tap_two, tap_four, tap_six, tap_eight, cycle_midpoint, error_latched;
   logic [2:0] ctrl_mode;
   int fail_count = 0; // Mismatches seen.
   int checked = 0; // Comparisons made.
   always #2 sys_clk = ~sys_clk;
   ctrl_model partner (.sys_clk(sys_clk), .rst(rst), .fast_clock(fast_clock),
      .delay_chain_clock(delay_chain_clock));
   dram_ecc_glue dut (.sys_clk(sys_clk), .rst(rst), .fast_clock(fast_clock),
      .delay_chain_clock(delay_chain_clock), .row_strobe_in(row_strobe_in),
      .refresh_request(refresh_request), .read_cycle(read_cycle), .any_error(any_error),
      .tap_two(tap_two), .tap_four(tap_four), .tap_six(tap_six), .tap_eight(tap_eight),
      .cycle_midpoint(cycle_midpoint), .error_latched(error_latched), .ctrl_mode(ctrl_mode));
   // Waits a number of rising edges, then lets their updates settle.
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   // Compares one output bit against its expected value.
   task automatic chk(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask : chk
   // Starts one cycle and walks the tap chain, checking each tap's moment.
   task automatic run_cycle(input logic rd, input logic err, input logic exp_err);
      read_cycle = rd;
      any_error = err;
      row_strobe_in = 1'b1;
      step(4);
      chk(tap_two, 1'b1, "tap two late");
      chk(tap_four, 1'b0, "tap four early");
      step(2);
      chk(tap_four, 1'b1, "tap four late");
      chk(tap_six, 1'b0, "tap six early");
      step(2);
      chk(tap_six, 1'b1, "tap six late");
      chk(cycle_midpoint, 1'b1, "midpoint missing");
      step(2);
      chk(tap_eight, 1'b1, "tap eight late");
      chk(error_latched, exp_err, "error latch wrong");
      row_strobe_in = 1'b0;
      any_error = 1'b0;
      step(12);
      chk(tap_eight, 1'b0, "tap eight stuck");
      chk(error_latched, 1'b0, "error latch not cleared");
   endtask : run_cycle
   // Read with an error, then a write with an error.
   task automatic test_read_write;
      run_cycle(1'b1, 1'b1, 1'b1);
      run_cycle(1'b0, 1'b1, 1'b0);
      $display("test read_write done");
   endtask : test_read_write
   // Refresh over a read level with an error: refresh mode, taps run, no latch.
   task automatic test_refresh;
      refresh_request = 1'b1;
      read_cycle = 1'b1;
      any_error = 1'b1;
      step(2);
      chk(ctrl_mode === MODE_REFRESH, 1'b1, "refresh mode missing");
      step(2);
      chk(tap_two, 1'b1, "refresh tap two late");
      step(4);
      chk(cycle_midpoint, 1'b1, "refresh midpoint missing");
      chk(error_latched, 1'b0, "error latched in refresh");
      refresh_request = 1'b0;
      read_cycle = 1'b0;
      any_error = 1'b0;
      step(2);
      chk(ctrl_mode === MODE_NORMAL, 1'b1, "normal mode missing");
      step(12);
      $display("test refresh done");
   endtask : test_refresh
   // Reset in the middle of a read with an error clears taps and latch.
   task automatic test_reset;
      read_cycle = 1'b1;
      any_error = 1'b1;
      row_strobe_in = 1'b1;
      step(10);
      rst = 1'b1;
      step(1);
      chk(tap_two | tap_four | tap_six | tap_eight, TAP_RESET, "taps not reset");
      chk(error_latched, TAP_RESET, "latch not reset");
      row_strobe_in = 1'b0;
      any_error = 1'b0;
      rst = 1'b0;
      step(12);
      chk(tap_eight, TAP_RESET, "tap eight after reset");
      $display("test reset done");
   endtask : test_reset
   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("checked %0d, fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   // Main sequence: reset for three cycles, then each test in turn.
   initial begin
      step(3);
      rst = 1'b0;
      step(1);
      test_read_write();
      test_refresh();
      test_reset();
      test_done();
   end
   // Watchdog, well past the roughly 93 cycles the tests need.
   initial begin
      #20000;
      fail_count++;
      test_done();
   end
endmodule : testbench
`default_nettype wire
